// ==== common/exp_wait_cfg.svh ====
/*
 Constants for the expansion bus wait and ready logic: widths, counts and
 the chip select window that may run in host-port mode.
 Assumes it is included by the package and the design file by bare name.
*/
`ifndef EXP_WAIT_CFG_SVH
`define EXP_WAIT_CFG_SVH

// Width of every phase counter, in bits; counts are expansion bus clock periods.
`define EXW_CNT_W 4
// Number of chip selects sharing the wait request.
`define EXW_CS_COUNT 8
// Number of dedicated host-port ready lines.
`define EXW_RDY_LINES 4
// First chip select that may run in host-port mode.
`define EXW_HP_FIRST_CS 3'h4
// Synchroniser stages on every pin input.
`define EXW_SYNC_STAGES 3

`endif

// ==== common/exp_wait_pkg.sv ====
/*
 Types for the expansion bus wait and ready logic: chip select modes,
 access phases and the access request carrier.
 Assumes exp_wait_cfg.svh is on the include path.
*/
`include "exp_wait_cfg.svh"

package exp_wait_pkg;

   // Bus mode of one chip select.
   typedef enum logic [1:0] {
      mode_strobe_pair,
      mode_strobe_pair_sync,
      mode_rw_line,
      mode_host_port
   } cs_mode_type;

   // Phases of one access.
   typedef enum logic [2:0] {
      ph_idle,
      ph_address,
      ph_setup,
      ph_strobe,
      ph_hold
   } phase_type;

   // One access request with its phase counts.
   typedef struct packed {
      logic [2:0] cs;
      logic write;
      logic [`EXW_CNT_W-1:0] t_address;
      logic [`EXW_CNT_W-1:0] t_setup;
      logic [`EXW_CNT_W-1:0] t_strobe;
      logic [`EXW_CNT_W-1:0] t_hold;
   } access_req_type;

endpackage : exp_wait_pkg

// ==== src/expansion_bus_wait_ready.sv ====
/*
 Expansion bus access sequencer with shared wait request and per chip
 select host-port ready handling.
 Assumes requests come from logic on ref_clk; the wait and ready pins are
 asynchronous and are synchronised here.
*/
// Functional notes
// - Shared wait works for strobe-pair and read-write modes.
// - Wait ignored on synchronous strobe-pair writes.
// - Active wait holds the strobe phase.
// - After release, strobe counts down then hold.
// - Wait only acts during the strobe phase.
// - Host-port chip selects four to seven use ready.
// - Host-port ready polarity is configurable.
// - Ready zero is select four, three seven.
// - Active ready holds address and strobe phases.
// - All counts are expansion bus clock periods.
`timescale 1ns/1ps
`default_nettype none
`include "exp_wait_cfg.svh"

module expansion_bus_wait_ready #(
   parameter int CS_COUNT = `EXW_CS_COUNT,
   parameter int RDY_LINES = `EXW_RDY_LINES
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire exp_wait_pkg::access_req_type req,
   input wire exp_wait_pkg::cs_mode_type cs_mode [CS_COUNT],
   input wire logic [RDY_LINES-1:0] ready_polarity,
   input wire logic shared_wait_request_n,
   input wire logic [RDY_LINES-1:0] host_port_ready_lines,
   output logic req_ready,
   output logic [CS_COUNT-1:0] chip_select_n,
   output logic read_strobe_n,
   output logic write_strobe_n,
   output logic access_done,
   output var exp_wait_pkg::phase_type phase_out
);
   import exp_wait_pkg::*;

   localparam int SW = RDY_LINES + 1;

   // Maps a host-port chip select onto its ready line index.
   function automatic logic [1:0] ready_index(input logic [2:0] cs);
      ready_index = cs[1:0];
   endfunction : ready_index

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: bit 0 is the wait request, the rest ready lines.

   logic [SW-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;

   // A change is accepted only once the second and third stage agree, so
   // a single metastable sample can never reach the sequencer.
   always_comb begin
      filt_d = filt_q;
      if (s2_q == s3_q) begin
         filt_d = s3_q;
      end
   end

   // Stage registers; the first stage feeds only the second.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= {SW{1'b1}};
         s2_q <= {SW{1'b1}};
         s3_q <= {SW{1'b1}};
         filt_q <= {SW{1'b1}};
      end else begin
         s1_q <= {host_port_ready_lines, shared_wait_request_n};
         s2_q <= s1_q;
         s3_q <= s2_q;
         filt_q <= filt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Access sequencer.

   phase_type state_q, state_d;
   access_req_type cur_q, cur_d;
   logic [`EXW_CNT_W-1:0] cnt_q, cnt_d;
   logic [CS_COUNT-1:0] cs_n_d;
   logic rd_n_d, wr_n_d, done_d, rdy_out_d;
   logic wait_act, uses_wait, host_mode, rdy_act, strobe_stall;
   cs_mode_type mode;

   // Stall sources for the access in flight.
   always_comb begin
      mode = cs_mode[cur_q.cs];
      wait_act = !filt_q[0];
      uses_wait = (mode == mode_strobe_pair) || (mode == mode_rw_line)
         || (mode == mode_strobe_pair_sync && !cur_q.write);
      host_mode = (mode == mode_host_port)
         && (cur_q.cs >= `EXW_HP_FIRST_CS);
      rdy_act = host_mode && (filt_q[1 + ready_index(cur_q.cs)]
         == ready_polarity[ready_index(cur_q.cs)]);
      strobe_stall = (uses_wait && wait_act) || rdy_act;
   end

   // Each phase lasts its count plus one clock unless stalled; the counter only moves in
   // whole bus clock periods, so no analogue timing is assumed.
   always_comb begin
      state_d = state_q;
      cur_d = cur_q;
      cnt_d = cnt_q;
      done_d = 1'b0;
      case (state_q)
         ph_idle: begin
            if (req_valid) begin
               cur_d = req;
               cnt_d = req.t_address;
               state_d = ph_address;
            end
         end
         ph_address: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - 1'b1;
            end else if (!rdy_act) begin
               cnt_d = cur_q.t_setup;
               state_d = ph_setup;
            end
         end
         ph_setup: begin
            // Wait is not looked at here; only the strobe phase reacts.
            if (cnt_q != '0) begin
               cnt_d = cnt_q - 1'b1;
            end else begin
               cnt_d = cur_q.t_strobe;
               state_d = ph_strobe;
            end
         end
         ph_strobe: begin
            if (!strobe_stall) begin
               if (cnt_q != '0) begin
                  cnt_d = cnt_q - 1'b1;
               end else begin
                  cnt_d = cur_q.t_hold;
                  state_d = ph_hold;
               end
            end
         end
         ph_hold: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - 1'b1;
            end else begin
               done_d = 1'b1;
               state_d = ph_idle;
            end
         end
         default: begin
            state_d = ph_idle;
         end
      endcase
   end

   // Pin levels follow the next phase so that every output is a flop.
   always_comb begin
      cs_n_d = {CS_COUNT{1'b1}};
      if (state_d != ph_idle) begin
         cs_n_d[cur_d.cs] = 1'b0;
      end
      rd_n_d = !(state_d == ph_strobe && !cur_d.write);
      wr_n_d = !(state_d == ph_strobe && cur_d.write);
      rdy_out_d = (state_d == ph_idle);
   end

   // Sequencer and pin registers.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ph_idle;
         cur_q <= '0;
         cnt_q <= '0;
         chip_select_n <= {CS_COUNT{1'b1}};
         read_strobe_n <= 1'b1;
         write_strobe_n <= 1'b1;
         access_done <= 1'b0;
         req_ready <= 1'b0;
         phase_out <= ph_idle;
      end else begin
         state_q <= state_d;
         cur_q <= cur_d;
         cnt_q <= cnt_d;
         chip_select_n <= cs_n_d;
         read_strobe_n <= rd_n_d;
         write_strobe_n <= wr_n_d;
         access_done <= done_d;
         req_ready <= rdy_out_d;
         phase_out <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence wait_low_held;
      !shared_wait_request_n [*5];
   endsequence

   sequence strobe_released;
      state_q == ph_strobe && !strobe_stall;
   endsequence

   a_wait_sync_path: assert property (wait_low_held |-> !filt_q[0])
      else $error("Held wait request did not reach the sequencer.");

   a_wait_holds_strobe: assert property (
      state_q == ph_strobe && uses_wait && wait_act
      |=> state_q == ph_strobe && cnt_q == $past(cnt_q))
      else $error("Strobe phase left or counted while wait active.");

   a_sync_write_free: assert property (
      state_q == ph_strobe && mode == mode_strobe_pair_sync && cur_q.write
      && cnt_q == '0 |=> state_q == ph_hold)
      else $error("Synchronous write was stalled by wait request.");

   a_release_counts: assert property (
      strobe_released ##0 cnt_q != '0
      |=> state_q == ph_strobe && cnt_q == $past(cnt_q) - 1'b1)
      else $error("Strobe counter did not count after release.");

   a_hold_at_zero: assert property (
      strobe_released ##0 cnt_q == '0
      |=> state_q == ph_hold && write_strobe_n && read_strobe_n)
      else $error("Hold phase not entered at strobe count zero.");

   a_wait_only_strobe: assert property (
      state_q == ph_setup && cnt_q == '0 |=> state_q == ph_strobe)
      else $error("Wait level affected a phase other than strobe.");

   // A wait level left over from the previous access must not stretch
   // the address, setup or hold count of the next one.
   a_wait_no_effect: assert property (
      (state_q == ph_address || state_q == ph_setup || state_q == ph_hold)
      && cnt_q != '0 && wait_act |=> cnt_q == $past(cnt_q) - 1'b1)
      else $error("Wait level stretched a phase other than strobe.");

   a_ready_holds_addr: assert property (
      state_q == ph_address && rdy_act |=> state_q == ph_address)
      else $error("Address phase left while host-port ready active.");

   a_ready_cs_four: assert property (
      state_q == ph_strobe && host_mode && cur_q.cs == 3'h4
      && filt_q[1] == ready_polarity[0] |=> state_q == ph_strobe)
      else $error("Chip select four not held by ready line zero.");

   a_ready_cs_five: assert property (
      state_q == ph_strobe && host_mode && cur_q.cs == 3'h5
      && filt_q[2] == ready_polarity[1] |=> state_q == ph_strobe)
      else $error("Chip select five not held by ready line one.");

   a_ready_polarity: assert property (
      state_q == ph_strobe && host_mode && cnt_q == '0
      && filt_q[1 + ready_index(cur_q.cs)]
      != ready_polarity[ready_index(cur_q.cs)] |=> state_q == ph_hold)
      else $error("Inactive ready level still stalled the strobe.");

   a_strobe_pins: assert property (
      state_q == ph_strobe |-> chip_select_n[cur_q.cs] == 1'b0
      && (read_strobe_n != write_strobe_n))
      else $error("Strobe phase without one strobe and chip select.");

endmodule : expansion_bus_wait_ready
`default_nettype wire

// ==== tb/periph_model.sv ====
/*
 Far-side model: a peripheral that pulls the shared wait low and host
 ports that hold their ready lines, each for a set number of cycles.
 Assumes the bench changes the lengths only while the bus is idle.
*/
`timescale 1ns/1ps
`default_nettype none
module periph_model (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire exp_wait_pkg::phase_type phase_out,
   input wire logic [7:0] wait_len,
   input wire logic [7:0] rdy_len,
   input wire logic [3:0] rdy_sel,
   input wire logic [3:0] polarity,
   output logic shared_wait_request_n,
   output logic [3:0] host_port_ready_lines
);
   import exp_wait_pkg::*;
   int wait_left_q;
   int rdy_left_q;
   phase_type last_q;
   //////////////////////////////
   // Each hold starts when its phase first shows on the bus.
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_left_q <= 0;
         rdy_left_q <= 0;
         last_q <= ph_idle;
      end else begin
         last_q <= phase_out;
         if (phase_out == ph_setup && last_q != ph_setup)
            wait_left_q <= wait_len;
         else if (wait_left_q > 0)
            wait_left_q <= wait_left_q - 1;
         if (phase_out == ph_address && last_q != ph_address)
            rdy_left_q <= rdy_len;
         else if (rdy_left_q > 0)
            rdy_left_q <= rdy_left_q - 1;
      end
   end
   // The wait line has a pull-up, so a released line reads high.
   assign shared_wait_request_n = !(wait_left_q > 0);
   // A ready line not holding shows its inactive level.
   assign host_port_ready_lines = polarity ~^ (rdy_sel & {4{rdy_left_q > 0}});
endmodule : periph_model
`default_nettype wire

// ==== tb/expansion_bus_wait_ready_bench.sv ====
/*
 Bench for the wait and ready sequencer: timed accesses on every bus mode,
 stalled on each, and also unstalled on synchronous strobe-pair and host-port modes.
 Assumes periph_model drives the wait and ready pins.
*/
`timescale 1ns/1ps
`default_nettype none
module expansion_bus_wait_ready_bench;
   import exp_wait_pkg::*;
   logic ref_clk = 0, rst_n = 0, req_valid = 0;
   access_req_type req = '0;
   cs_mode_type cs_mode [8];
   logic [3:0] ready_polarity = 4'h0, rdy_sel = 4'h0;
   logic [7:0] wait_len = 8'h00, rdy_len = 8'h00;
   logic shared_wait_request_n, req_ready, access_done;
   logic read_strobe_n, write_strobe_n;
   logic [3:0] host_port_ready_lines;
   logic [7:0] chip_select_n;
   phase_type phase_out;
   int err_total = 0, checks_done = 0, lat, stb;
   localparam logic [2:0] T_CS [5] = '{0, 2, 1, 1, 4};
   localparam logic T_WR [5] = '{0, 1, 1, 0, 0};
   localparam logic T_ST [5] = '{1, 1, 0, 1, 0};
   //////////////////////////////
   expansion_bus_wait_ready u_expansion_bus_wait_ready (.ref_clk, .rst_n,
      .req_valid, .req, .cs_mode, .ready_polarity, .shared_wait_request_n,
      .host_port_ready_lines, .req_ready, .chip_select_n, .read_strobe_n,
      .write_strobe_n, .access_done, .phase_out);
   periph_model u_periph_model (.ref_clk, .rst_n, .phase_out, .wait_len,
      .rdy_len, .rdy_sel, .polarity(ready_polarity),
      .shared_wait_request_n, .host_port_ready_lines);
   // Free-running 40 MHz clock.
   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end
   //////////////////////////////
   task automatic complete_run();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run
   task automatic check_val(input logic [31:0] got, exp, input string s);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t %s got %0d exp %0d", $time, s, got, exp);
      end
   endtask : check_val
   task automatic check_bit(input logic got, input string s);
      check_val({31'h0, got}, 32'h1, s);
   endtask : check_bit
   // One access with all four counts at tc; counts cycles to done and
   // strobe. Each phase lasts tc plus one clock when nothing stalls.
   task automatic access(input logic [2:0] cs, input logic wr,
      input logic [3:0] tc);
      int n;
      n = 0;
      @(negedge ref_clk);
      while (req_ready !== 1'b1 && n < 50) begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= 50) begin
         err_total++;
         $display("ERROR %0t sequencer never idle", $time);
         complete_run();
      end
      req = '{cs, wr, tc, tc, tc, tc};
      req_valid = 1'b1;
      @(negedge ref_clk);
      req_valid = 1'b0;
      lat = 0;
      stb = 0;
      while (access_done !== 1'b1) begin
         @(negedge ref_clk);
         lat++;
         if (lat == 1) begin
            check_val(chip_select_n, 8'(~(8'h01 << cs)), "select");
            check_val(phase_out, ph_address, "phase");
         end
         if ((wr ? write_strobe_n : read_strobe_n) === 1'b0)
            stb++;
         if (lat > 200) begin
            err_total++;
            $display("ERROR %0t access never finished", $time);
            complete_run();
         end
      end
      check_val(chip_select_n, 8'hff, "select released");
      check_val(phase_out, ph_idle, "phase idle");
   endtask : access
   //////////////////////////////
   // Reset, then wait-request cases, then host-port ready cases.
   initial begin
      for (int i = 0; i < 8; i++)
         cs_mode[i] = (i > 3) ? mode_host_port : mode_strobe_pair;
      cs_mode[1] = mode_strobe_pair_sync;
      cs_mode[2] = mode_rw_line;
      repeat (5) @(negedge ref_clk);
      check_val(chip_select_n, 8'hff, "select in reset");
      check_bit(req_ready === 1'b0, "ready in reset");
      rst_n = 1'b1;
      @(negedge ref_clk);
      check_bit(req_ready, "ready after reset");
      $display("test reset done");
      wait_len = 8'h0c;
      for (int t = 0; t < 5; t++) begin
         access(T_CS[t], T_WR[t], 4'h3);
         check_bit((stb > 4) == T_ST[t], "wait stall");
         check_val(lat, 12 + stb, "latency");
      end
      $display("test wait done");
      wait_len = 8'h00;
      rdy_len = 8'h0c;
      for (int p = 0; p < 2; p++) begin
         ready_polarity = p ? 4'ha : 4'h5;
         repeat (6) @(negedge ref_clk);
         for (int i = 0; i < 4; i++) begin
            rdy_sel = 4'h1 << ((i + 1) % 4);
            access(3'(4 + i), 1'b0, 4'h3);
            check_val(lat, 16, "foreign ready");
            rdy_sel = 4'h1 << i;
            // Short counts: ready arrives in time to stall the strobe.
            access(3'(4 + i), 1'b0, 4'h3);
            check_bit(lat > 16, "own ready");
            // Long counts: ready arrives while the address phase runs.
            access(3'(4 + i), 1'b0, 4'h7);
            check_bit(lat > 32, "own ready address");
         end
      end
      $display("test host done");
      complete_run();
   end
endmodule : expansion_bus_wait_ready_bench
`default_nettype wire
